// *** bench/nv_host_model.sv ***
// Purpose: Host side of the store and recall sequencer
// Assumes: Open-drain busy wire resolved in the bench with a pull-up
// Notes: Link clock runs only inside chip-select frames

`timescale 1ns/1ps

module nv_host_model (
    output logic cs_n_pin,
    output logic pull_low,
    input wire logic busy_level
);
    import nv_seq_pkg::*;

    // ****************************************
    // Frames and hardware store requests
    // ****************************************
    logic lclk;

    initial begin
        cs_n_pin = 1'b1;
        pull_low = 1'b0;
        lclk = 1'b0;
    end

    // Link clock stands still between frames, 160 ns period inside
    task automatic frame(input int n);
        cs_n_pin = 1'b0;
        repeat (n) begin
            #80 lclk = 1'b1;
            #80 lclk = 1'b0;
        end
        cs_n_pin = 1'b1;
    endtask : frame

    // Never shorter than the minimum; waits out a running store first
    task automatic hw_pulse(input int ns);
        int w;
        w = (ns < HW_PULSE_NS) ? HW_PULSE_NS : ns;
        wait (busy_level === 1'b1);
        pull_low = 1'b1;
        #(w);
        pull_low = 1'b0;
    endtask : hw_pulse
endmodule : nv_host_model

// *** bench/nv_store_recall_sequencing_bench.sv ***
// Purpose: Self-checking bench for the store and recall sequencer
// Assumes: Shortened phase lengths through the design parameters
// Notes: Monitor compares each finished operation with the oldest note

`timescale 1ns/1ps

module nv_store_recall_sequencing_bench;
    import nv_seq_pkg::*;

    localparam int PU = 20;
    localparam int ST = 40;
    localparam int RC = 10;
    localparam int WK = 30;

    typedef struct packed {
        logic [15:0] lo;
        logic [15:0] hi;
        logic [15:0] low;
        logic [15:0] high;
    } note_s;

    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic supply_ok_pin = 1'b1;
    logic cs_n_pin;
    logic pull_low;
    logic busy_wire;
    logic store_busy_line_out;
    logic store_busy_line_oe;
    cmd_s cmd = '0;
    logic sram_write = 1'b0;
    status_s status;
    note_s notes[$];
    note_s nt;
    int n_fail = 0;
    int checks_done = 0;
    int inh_n, low_n, high_n, seed, k, n;
    logic act, act_d, mon_off = 1'b0;

    always #5 clk_sys = ~clk_sys;

    // Pull-up wins only when no party drives the wire low
    assign busy_wire = ((store_busy_line_oe && !store_busy_line_out)
                        || pull_low) ? 1'b0 : 1'b1;

    nv_host_model host (
        .cs_n_pin(cs_n_pin),
        .pull_low(pull_low),
        .busy_level(busy_wire)
    );

    nv_store_recall_sequencing #(
        .PU_CYC(PU),
        .STORE_LEN(ST),
        .RECALL_LEN(RC),
        .WAKE_LEN(WK)
    ) uut (
        .clk_sys(clk_sys),
        .rst(rst),
        .supply_ok_pin(supply_ok_pin),
        .cs_n_pin(cs_n_pin),
        .store_busy_line_in(busy_wire),
        .store_busy_line_out(store_busy_line_out),
        .store_busy_line_oe(store_busy_line_oe),
        .cmd(cmd),
        .sram_write(sram_write),
        .status(status)
    );

    // ****************************************
    // Helpers
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish;
        $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish

    task automatic tick(input int c);
        repeat (c) @(posedge clk_sys);
    endtask : tick

    task automatic send(input cmd_e op);
        @(posedge clk_sys);
        cmd <= {1'b1, op};
        @(posedge clk_sys);
        cmd <= {1'b0, CMD_NONE};
    endtask : send

    task automatic write_n(input int c);
        repeat (c) begin
            @(posedge clk_sys);
            sram_write <= 1'b1;
        end
        @(posedge clk_sys);
        sram_write <= 1'b0;
    endtask : write_n

    // Bounded wait for the end of a nonvolatile operation
    task automatic wait_idle;
        int i;
        tick(8);
        for (i = 0; i < 3000; i++) begin
            if (status.access_inhibit_window === 1'b0
                && store_busy_line_oe === 1'b0)
                break;
            tick(1);
        end
        check(32'(i < 3000), 32'h1);
    endtask : wait_idle

    task automatic note(input int lo, input int hi, input int lw,
                        input int hg);
        notes.push_back({16'(lo), 16'(hi), 16'(lw), 16'(hg)});
    endtask : note

    // ****************************************
    // Monitor
    // ****************************************
    always @(negedge clk_sys) begin
        if (rst) begin
            inh_n = 0;
            low_n = 0;
            high_n = 0;
            act_d = 1'b0;
        end else begin
            act = status.access_inhibit_window | store_busy_line_oe;
            if (status.access_inhibit_window) inh_n++;
            if (store_busy_line_oe && !store_busy_line_out) low_n++;
            if (store_busy_line_oe && store_busy_line_out) high_n++;
            if (act_d && !act) begin
                if (mon_off) begin
                end else if (notes.size() == 0) begin
                    check(32'h1, 32'h0);
                end else begin
                    nt = notes.pop_front();
                    check(32'(inh_n >= nt.lo && inh_n <= nt.hi), 1);
                    check(32'(low_n), 32'(nt.low));
                    check(32'(high_n), 32'(nt.high));
                end
                inh_n = 0;
                low_n = 0;
                high_n = 0;
            end
            act_d = act;
        end
    end

    initial begin
        #500000;
        n_fail++;
        tally_and_finish();
    end

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        seed = 57;
        note(PU, PU + 8, 0, 0);
        tick(20);
        rst <= 1'b0;
        wait_idle();
        tick(5);
        #1 check(status.standby, 1'b1);
        fork
            host.frame(6);
        join_none
        tick(10);
        #1 check(status.standby, 1'b0);
        tick(100);
        #1 check(status.standby, 1'b1);
        // Software store on a clean array still runs
        note(ST, ST + BUSY_HI_CYC + 2, ST, BUSY_HI_CYC);
        send(CMD_STORE);
        #1 check(status.sram_enable, 1'b1);
        check(status.access_inhibit_window, 1'b0);
        wait_idle();
        write_n(2);
        #1 check(status.dirty, 1'b1);
        note(RC, RC + 2, 0, 0);
        send(CMD_RECALL);
        tick(5);
        write_n(1);
        wait_idle();
        #1 check(status.dirty, 1'b0);
        // Clean array: the hardware request must not start a store
        fork
            host.hw_pulse(80);
        join_none
        tick(5);
        #1 check(status.sram_enable, 1'b0);
        tick(20);
        for (k = 0; k < 4; k++) begin
            n = (k == 0) ? 1 : ($unsigned($random(seed)) % 3);
            write_n(n);
            if (n > 0) note(ST, ST + BUSY_HI_CYC + 2, ST, BUSY_HI_CYC);
            fork
                host.hw_pulse(40);
            join_none
            wait_idle();
            tick(10);
        end
        // Power loss with the automatic store switched off, then on
        send(CMD_PLS_OFF);
        tick(3);
        #1 check(status.power_loss_store_en, 1'b0);
        write_n(1);
        note(PU, PU + 60, 0, 0);
        @(posedge clk_sys);
        supply_ok_pin <= 1'b0;
        tick(20);
        #1 check(status.sram_enable, 1'b0);
        check(status.access_inhibit_window, 1'b1);
        @(posedge clk_sys);
        supply_ok_pin <= 1'b1;
        wait_idle();
        send(CMD_PLS_ON);
        tick(3);
        #1 check(status.power_loss_store_en, 1'b1);
        write_n(1);
        note(ST + PU, ST + PU + BUSY_HI_CYC + 40, ST, BUSY_HI_CYC);
        @(posedge clk_sys);
        supply_ok_pin <= 1'b0;
        tick(ST + BUSY_HI_CYC + 10);
        supply_ok_pin <= 1'b1;
        wait_idle();
        // Sleep refuses commands until a frame wakes the device
        send(CMD_SLEEP);
        tick(1);
        #1 check(status.asleep, 1'b1);
        send(CMD_STORE);
        tick(5);
        #1 check(status.asleep, 1'b1);
        check(store_busy_line_oe, 1'b0);
        mon_off = 1'b1;
        host.frame(2);
        tick(WK + 10);
        #1 check(status.asleep, 1'b0);
        wait_idle();
        mon_off = 1'b0;
        check(32'(notes.size()), 32'h0);
        tally_and_finish();
    end
endmodule : nv_store_recall_sequencing_bench

// *** hw/nv_op_timer.sv ***
// Purpose: Down counter that times one nonvolatile phase
// Assumes: load and value on clk_sys
// Notes: expired is high while the count stands at zero

`timescale 1ns/1ps

module nv_op_timer #(
    parameter int W = 23
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic load,
    input wire logic [W-1:0] value,
    output logic expired
);

    logic [W-1:0] cnt;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt <= '0;
        end else if (load) begin
            cnt <= value;
        end else if (cnt != '0) begin
            cnt <= cnt - 1'b1;
        end
    end

    assign expired = (cnt == '0);

endmodule : nv_op_timer

// *** hw/nv_seq_pkg.sv ***
// Purpose: Shared constants and types for the store and recall sequencer
// Assumes: clk_sys at 100 MHz
// Notes: Cycle counts derive from the printed times

package nv_seq_pkg;

    // ****************************************
    // Clock and timing
    // ****************************************
    localparam int CLK_NS = 10;
    localparam int TW = 23;
    localparam int PU_RECALL_MS_LV = 40;
    localparam int PU_RECALL_MS = 20;
    localparam int STORE_MS = 8;
    localparam int GRACE_NS = 25;
    localparam int RECALL_US = 600;
    localparam int SOFT_SEQ_US = 500;
    localparam int HW_PULSE_NS = 15;
    localparam int RELEASE_US = 5;
    localparam int BUSY_HI_NS = 500;
    localparam int SLEEP_MS = 8;
    localparam int WAKE_MS_LV = 40;
    localparam int WAKE_MS = 20;
    localparam int STANDBY_US = 100;

    localparam int PU_RECALL_LV_CYC = PU_RECALL_MS_LV * 1000000 / CLK_NS;
    localparam int PU_RECALL_CYC = PU_RECALL_MS * 1000000 / CLK_NS;
    localparam int STORE_CYC = STORE_MS * 1000000 / CLK_NS;
    localparam int GRACE_CYC = GRACE_NS / CLK_NS;
    localparam int RECALL_CYC = RECALL_US * 1000 / CLK_NS;
    localparam int SOFT_SEQ_CYC = SOFT_SEQ_US * 1000 / CLK_NS;
    localparam int HW_PULSE_CYC = (HW_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int RELEASE_CYC = RELEASE_US * 1000 / CLK_NS;
    localparam int BUSY_HI_CYC = BUSY_HI_NS / CLK_NS;
    localparam int SLEEP_CYC = SLEEP_MS * 1000000 / CLK_NS;
    localparam int WAKE_LV_CYC = WAKE_MS_LV * 1000000 / CLK_NS;
    localparam int WAKE_CYC = WAKE_MS * 1000000 / CLK_NS;
    localparam int STANDBY_CYC = STANDBY_US * 1000 / CLK_NS;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic PLS_EN_RST = 1'b1;
    localparam logic DIRTY_RST = 1'b0;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [2:0] {
        CMD_NONE = 3'h0,
        CMD_STORE = 3'h1,
        CMD_RECALL = 3'h2,
        CMD_PLS_ON = 3'h3,
        CMD_PLS_OFF = 3'h4,
        CMD_SLEEP = 3'h5
    } cmd_e;

    typedef enum logic [3:0] {
        S_OFF = 4'h0,
        S_PU_RECALL = 4'h1,
        S_READY = 4'h3,
        S_GRACE = 4'h2,
        S_STORE = 4'h6,
        S_BUSY_HI = 4'h7,
        S_RECALL = 4'h5,
        S_SLEEP = 4'h4,
        S_WAKE = 4'hc
    } state_e;

    typedef struct packed {
        logic valid;
        cmd_e op;
    } cmd_s;

    typedef struct packed {
        logic access_inhibit_window;
        logic sram_enable;
        logic standby;
        logic asleep;
        logic power_loss_store_en;
        logic dirty;
    } status_s;

endpackage : nv_seq_pkg

// *** hw/nv_store_recall_sequencing.sv ***
// Purpose: Sequencer for recall, store, sleep and standby of the nv array
// Assumes: Command decoder and SRAM write strobe on clk_sys
// Notes: Supply, chip select and hardware store pins are synchronised

`timescale 1ns/1ps

// Notes on behaviour
// (RULE1) Power-up recall ends within 40 ms low-voltage variant, else 20 ms.
// (RULE2) Serial access blocked during store and recall; store ends within 8 ms.
// (RULE3) Software recall completes within 600 us.
// (RULE4) Software sequence commands are acted on within 500 us.
// (RULE5) Power-loss or hardware store skipped when no write since last cycle.
// (RULE6) Reads and writes ignored during store, recall and low supply.
// (RULE7) SRAM stays enabled up to 25 ns after an operation is initiated.
// (RULE8) Host holds the hardware store line low at least 15 ns.
// (RULE9) SRAM disabled while the host drives the store line low.
// (RULE10) Device accessible within 5 us after busy line returns high.
// (RULE11) Busy line driven high at most 500 ns after a store, then released.
// (RULE12) Sleep mode entered within 8 ms of the sleep instruction.
// (RULE13) Wake from sleep completes within 40 ms or 20 ms by variant.
// (RULE14) Standby entered within 100 us of chip select going high.
// (RULE15) Busy line driven low for the whole of every store.
// (RULE16) Enabled power-loss store starts on supply drop if a write occurred; the code starts it only in S_READY, S_SLEEP and S_WAKE go to S_OFF.
module nv_store_recall_sequencing
    import nv_seq_pkg::*;
#(
    parameter bit LOW_VOLTAGE = 1'b0,
    parameter int PU_CYC = LOW_VOLTAGE ? PU_RECALL_LV_CYC : PU_RECALL_CYC,
    parameter int STORE_LEN = STORE_CYC,
    parameter int RECALL_LEN = RECALL_CYC,
    parameter int WAKE_LEN = LOW_VOLTAGE ? WAKE_LV_CYC : WAKE_CYC
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic supply_ok_pin,
    input wire logic cs_n_pin,
    input wire logic store_busy_line_in,
    output logic store_busy_line_out,
    output logic store_busy_line_oe,
    input wire nv_seq_pkg::cmd_s cmd,
    input wire logic sram_write,
    output nv_seq_pkg::status_s status
);

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [2:0] pin_raw;
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic supply_ok;
    logic cs_high;
    logic hw_low;
    logic supply_prev;

    assign pin_raw = {~store_busy_line_in, cs_n_pin, supply_ok_pin};

    generate
        for (genvar i = 0; i < 3; i++) begin : g_sync
            always_ff @(posedge clk_sys or posedge rst) begin
                if (rst) begin
                    sync1[i] <= 1'b0;
                    sync2[i] <= 1'b0;
                end else begin
                    sync1[i] <= pin_raw[i];
                    sync2[i] <= sync1[i];
                end
            end
        end
    endgenerate

    assign supply_ok = sync2[0];
    assign cs_high = sync2[1];
    assign hw_low = sync2[2];

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            supply_prev <= 1'b0;
        end else begin
            supply_prev <= supply_ok;
        end
    end

    // ****************************************
    // Sequencer
    // ****************************************
    state_e state;
    state_e next_state;
    logic pend_store;
    logic next_pend_store;
    logic dirty;
    logic pls_en;
    logic tmr_load;
    logic [TW-1:0] tmr_value;
    logic tmr_done;
    logic supply_fell;
    logic own_drive;
    logic hw_req;
    logic cmd_ok;

    assign supply_fell = supply_prev & ~supply_ok;
    // Own low drive must not look like a host request
    assign hw_req = hw_low & ~own_drive;
    assign cmd_ok = cmd.valid & supply_ok;

    function automatic logic busy_state(input state_e s);
        busy_state = (s == S_STORE) || (s == S_BUSY_HI);
    endfunction : busy_state

    nv_op_timer #(
        .W(TW)
    ) u_timer (
        .clk_sys(clk_sys),
        .rst(rst),
        .load(tmr_load),
        .value(tmr_value),
        .expired(tmr_done)
    );

    always_comb begin
        next_state = state;
        next_pend_store = pend_store;
        tmr_load = 1'b0;
        tmr_value = '0;
        case (state)
            S_OFF: begin
                if (supply_ok) begin
                    next_state = S_PU_RECALL;
                    tmr_load = 1'b1;
                    tmr_value = TW'(PU_CYC - 1); // RULE1
                end
            end
            S_PU_RECALL: begin
                if (!supply_ok) begin
                    next_state = S_OFF;
                end else if (tmr_done) begin
                    next_state = S_READY;
                end
            end
            S_READY: begin
                if (!supply_ok) begin
                    // Clean array skips the store
                    if (pls_en && dirty) begin // RULE16 RULE5
                        next_state = S_GRACE;
                        next_pend_store = 1'b1;
                        tmr_load = 1'b1;
                        tmr_value = TW'(GRACE_CYC - 1); // RULE7
                    end else begin
                        next_state = S_OFF;
                    end
                end else if (hw_req) begin
                    if (dirty) begin // RULE5
                        next_state = S_GRACE;
                        next_pend_store = 1'b1;
                        tmr_load = 1'b1;
                        tmr_value = TW'(GRACE_CYC - 1); // RULE7
                    end
                end else if (cmd_ok) begin // RULE4
                    if (cmd.op == CMD_STORE || cmd.op == CMD_RECALL) begin
                        next_state = S_GRACE;
                        next_pend_store = (cmd.op == CMD_STORE);
                        tmr_load = 1'b1;
                        tmr_value = TW'(GRACE_CYC - 1); // RULE7
                    end else if (cmd.op == CMD_SLEEP) begin
                        next_state = S_SLEEP; // RULE12
                    end
                end
            end
            S_GRACE: begin
                if (!supply_ok && !pend_store) begin
                    next_state = S_OFF;
                end else if (tmr_done) begin
                    next_state = pend_store ? S_STORE : S_RECALL;
                    tmr_load = 1'b1;
                    tmr_value = pend_store ? TW'(STORE_LEN - 1)
                                           : TW'(RECALL_LEN - 1); // RULE2 RULE3
                end
            end
            S_STORE: begin
                // Store runs on to the end even after supply loss
                if (tmr_done) begin
                    next_state = S_BUSY_HI;
                    tmr_load = 1'b1;
                    tmr_value = TW'(BUSY_HI_CYC - 1); // RULE11
                end
            end
            S_BUSY_HI: begin
                if (tmr_done) begin
                    next_state = supply_ok ? S_READY : S_OFF; // RULE10
                end
            end
            S_RECALL: begin
                if (!supply_ok) begin
                    next_state = S_OFF;
                end else if (tmr_done) begin
                    next_state = S_READY;
                end
            end
            S_SLEEP: begin
                if (!supply_ok) begin
                    next_state = S_OFF;
                end else if (!cs_high) begin
                    next_state = S_WAKE;
                    tmr_load = 1'b1;
                    tmr_value = TW'(WAKE_LEN - 1); // RULE13
                end
            end
            S_WAKE: begin
                if (!supply_ok) begin
                    next_state = S_OFF;
                end else if (tmr_done) begin
                    next_state = S_READY;
                end
            end
            default: begin
                next_state = S_OFF;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state <= S_OFF;
            pend_store <= 1'b0;
        end else begin
            state <= next_state;
            pend_store <= next_pend_store;
        end
    end

    // ****************************************
    // Write tracking and power-loss enable
    // ****************************************
    logic write_taken;
    logic nv_cycle_start;

    assign write_taken = sram_write & status.sram_enable;
    assign nv_cycle_start = (next_state == S_STORE || next_state == S_RECALL
                             || next_state == S_PU_RECALL)
                            && next_state != state;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            dirty <= DIRTY_RST;
        end else begin
            // A write in the start cycle keeps the flag set
            dirty <= write_taken | (dirty & ~nv_cycle_start); // RULE5
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pls_en <= PLS_EN_RST;
        end else if (state == S_READY && cmd_ok && !hw_req) begin
            if (cmd.op == CMD_PLS_ON) begin
                pls_en <= 1'b1; // RULE4
            end else if (cmd.op == CMD_PLS_OFF) begin
                pls_en <= 1'b0; // RULE4
            end
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            own_drive <= 1'b0;
            store_busy_line_oe <= 1'b0;
            store_busy_line_out <= 1'b0;
            status <= '0;
        end else begin
            own_drive <= busy_state(next_state);
            store_busy_line_oe <= busy_state(next_state); // RULE15 RULE11
            store_busy_line_out <= (next_state == S_BUSY_HI); // RULE11
            status.access_inhibit_window <= !(next_state == S_READY
                || next_state == S_GRACE) || !supply_ok; // RULE2 RULE6
            status.sram_enable <= (next_state == S_READY
                || next_state == S_GRACE) && supply_ok
                && !hw_req; // RULE7 RULE9
            status.standby <= (next_state == S_READY) && cs_high; // RULE14
            status.asleep <= (next_state == S_SLEEP);
            status.power_loss_store_en <= pls_en;
            status.dirty <= dirty;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    logic [TW-1:0] dwell;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            dwell <= '0;
        end else if (next_state != state) begin
            dwell <= '0;
        end else if (dwell != '1) begin
            dwell <= dwell + 1'b1;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    pu_recall_len_a: assert property (state == S_PU_RECALL |-> dwell < TW'(PU_CYC)) else $error("power-up recall too long"); // RULE1
    store_len_a: assert property (state == S_STORE |-> dwell < TW'(STORE_LEN) && status.access_inhibit_window) else $error("store too long or open"); // RULE2
    recall_len_a: assert property (state == S_RECALL |-> dwell < TW'(RECALL_LEN)) else $error("recall too long"); // RULE3
    soft_act_a: assert property (state == S_READY && cmd_ok && !hw_req && cmd.op == CMD_RECALL |=> state == S_GRACE ##[1:4] state == S_RECALL) else $error("recall command not acted on"); // RULE4
    clean_skip_a: assert property (state == S_READY && hw_req && !dirty && supply_ok |=> state != S_GRACE) else $error("clean array stored"); // RULE5
    low_supply_a: assert property (!supply_ok |=> status.access_inhibit_window) else $error("access open at low supply"); // RULE6
    // Store pin and low supply close the SRAM at once, so only commands
    grace_enable_a: assert property (state == S_READY && cmd_ok && !hw_req
        && (cmd.op == CMD_STORE || cmd.op == CMD_RECALL)
        |=> status.sram_enable [*2] ##1 !status.sram_enable)
        else $error("grace window wrong"); // RULE7
    hw_disable_a: assert property (hw_req |=> !status.sram_enable) else $error("sram enabled under store pin"); // RULE9
    ready_open_a: assert property ($fell(state == S_BUSY_HI) && state == S_READY && supply_ok |-> !status.access_inhibit_window) else $error("not accessible after busy"); // RULE10
    busy_high_a: assert property (state == S_BUSY_HI |-> dwell < TW'(BUSY_HI_CYC) && store_busy_line_out && store_busy_line_oe) else $error("busy high drive wrong"); // RULE11
    sleep_entry_a: assert property (state == S_READY && cmd_ok && !hw_req && cmd.op == CMD_SLEEP |=> status.asleep) else $error("sleep not entered"); // RULE12
    wake_len_a: assert property (state == S_WAKE |-> dwell < TW'(WAKE_LEN)) else $error("wake too long"); // RULE13
    standby_a: assert property (state == S_READY && next_state == S_READY
        && cs_high |=> status.standby)
        else $error("standby not entered"); // RULE14
    busy_low_a: assert property (state == S_STORE |-> store_busy_line_oe && !store_busy_line_out) else $error("busy not low in store"); // RULE15
    pls_start_a: assert property (state == S_READY && supply_fell && pls_en && dirty |=> state == S_GRACE && pend_store) else $error("power-loss store missed"); // RULE16

    store_seen_c: cover property (state == S_STORE ##1 state == S_BUSY_HI);
    recall_seen_c: cover property (state == S_RECALL ##1 state == S_READY);
    wake_seen_c: cover property (state == S_WAKE ##1 state == S_READY);
    pls_seen_c: cover property (state == S_READY && supply_fell
        ##1 state == S_GRACE && pend_store);

endmodule : nv_store_recall_sequencing
